// ### design/bca_dev.sv
// Bonded channel group: clock source muxing, start hop chain, alignment
`timescale 1ns/100ps
`default_nettype none
module bca_dev #(
  parameter int NUM_CH = bca_pkg::NUM_CH_DEF,
  parameter int BANK_CH = bca_pkg::BANK_CH_DEF,
  parameter int WORD_DIV = bca_pkg::WORD_DIV_DEF,
  parameter int CASC_DIV = bca_pkg::CASC_DIV_DEF
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Link to fabric side
  bca_if.dev LINK,
  // Per-channel status
  output logic [NUM_CH-1:0] TX_ACTIVE,
  output logic [NUM_CH-1:0] WORD_LOAD,
  output logic [NUM_CH-1:0] SRC_MASTER
);
  localparam int MID = NUM_CH / 2;
  localparam int UPPER = NUM_CH - 1 - MID;
  localparam int MAXHOP = (MID > UPPER) ? MID : UPPER;
  localparam int ALIGN = MAXHOP * bca_pkg::HOP_CYCLES;
  localparam int DW = $clog2(WORD_DIV);
  localparam int CW = $clog2(CASC_DIV);
  localparam int AW = $clog2(ALIGN + 2);
  localparam logic [DW-1:0] DIV_LAST = DW'(WORD_DIV - 1);
  localparam logic [CW-1:0] CASC_LAST = CW'(CASC_DIV - 1);
  localparam logic [AW-1:0] ALIGN_LAST = AW'(ALIGN);

  generate
    if (NUM_CH < 2 || BANK_CH < 1 || WORD_DIV < 2 || CASC_DIV < 2)
    begin : g_bad
      $error("bca_dev: NUM_CH>=2, BANK_CH>=1, dividers>=2 required");
    end
  endgenerate

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ALIGN = 2'b01,
    ST_RUN = 2'b10
  } bca_grp_t;

  bca_grp_t state_reg, state_next;
  logic [AW-1:0] align_cnt_reg, align_cnt_next;

  // Mode decode
  wire bonded = bca_pkg::is_bonded(LINK.mode);
  wire pcs_bonded = bca_pkg::is_pcs_bonded(LINK.mode);
  wire clk_ok = LINK.serial_clk_ok;

  // Master divider fed over the single-bank net, then bank and multi-bank nets
  logic [DW-1:0] mdiv_reg;
  logic bank_tick_reg;
  logic multi_tick_reg;
  wire mdiv_run = bonded & clk_ok;
  wire master_tick = mdiv_run & (mdiv_reg == DIV_LAST);

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      mdiv_reg <= '0;
      bank_tick_reg <= 1'b0;
      multi_tick_reg <= 1'b0;
    end
    else
    begin
      mdiv_reg <= !mdiv_run ? '0 : (master_tick ? '0 : mdiv_reg + 1'b1);
      bank_tick_reg <= master_tick;
      multi_tick_reg <= bank_tick_reg;
    end
  end

  // Group sequencing
  wire start_take = (state_reg == ST_IDLE) & LINK.start_req & pcs_bonded & clk_ok;
  wire master_start = start_take;
  wire align_done = (state_reg == ST_ALIGN) & (align_cnt_reg == ALIGN_LAST);

  always_comb
  begin
    state_next = state_reg;
    align_cnt_next = align_cnt_reg;
    case (state_reg)
      ST_IDLE:
      begin
        align_cnt_next = '0;
        if (start_take)
          state_next = ST_ALIGN;
      end
      ST_ALIGN:
      begin
        align_cnt_next = align_cnt_reg + 1'b1;
        if (!pcs_bonded || !clk_ok)
          state_next = ST_IDLE;
        else if (align_done)
          state_next = ST_RUN;
      end
      ST_RUN:
      begin
        if (!pcs_bonded || !clk_ok)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Start hop chain outward from the centre
  logic [NUM_CH-1:0] arrive;
  logic [NUM_CH-1:0] aligned;
  logic [NUM_CH-1:0] en_rise;
  logic [NUM_CH-1:0] go;
  logic [NUM_CH-1:0] tick_sel;
  logic [NUM_CH-1:0] active_next;
  logic [NUM_CH-1:0] en_q_reg;
  logic [1:0] hop_reg [NUM_CH];
  logic [ALIGN-1:0] comp_reg [NUM_CH];
  logic [DW-1:0] ldiv_reg [NUM_CH];

  genvar k;
  generate
    for (k = 0; k < NUM_CH; k++)
    begin : g_ch
      localparam int DIST = (k > MID) ? (k - MID) : (MID - k);
      localparam int TAP = (MAXHOP - DIST) * bca_pkg::HOP_CYCLES;
      wire local_tick = LINK.chan_en[k] & clk_ok & (ldiv_reg[k] == DIV_LAST);
      wire far_tick = (k < BANK_CH) ? bank_tick_reg : multi_tick_reg;

      if (k == MID)
      begin : g_master
        assign arrive[k] = master_start;
      end
      else if (k < MID)
      begin : g_lower
        assign arrive[k] = hop_reg[k+1][1];
      end
      else
      begin : g_upper
        assign arrive[k] = hop_reg[k-1][1];
      end

      if (TAP == 0)
      begin : g_notap
        assign aligned[k] = arrive[k];
      end
      else
      begin : g_tap
        assign aligned[k] = comp_reg[k][TAP-1];
      end

      assign en_rise[k] = LINK.chan_en[k] & ~en_q_reg[k];
      // Analog-only and non-bonded: each channel starts on its own release
      assign go[k] = pcs_bonded ? aligned[k] : en_rise[k];
      assign tick_sel[k] = bonded ? far_tick : local_tick;
      assign active_next[k] = LINK.chan_en[k] & (TX_ACTIVE[k] | go[k]);

      always_ff @(posedge SYS_CLK)
      begin
        if (RST)
        begin
          hop_reg[k] <= '0;
          comp_reg[k] <= '0;
          ldiv_reg[k] <= '0;
        end
        else
        begin
          hop_reg[k] <= {hop_reg[k][0], arrive[k]};
          comp_reg[k] <= {comp_reg[k][ALIGN-2:0], arrive[k]};
          // Local divider phase restarts with each FIFO reset release
          ldiv_reg[k] <= (!LINK.chan_en[k] || local_tick) ? '0 : ldiv_reg[k] + 1'b1;
        end
      end
    end
  endgenerate

  // Cascading net: fractional synth output divider
  logic [CW-1:0] casc_cnt_reg;
  logic casc_tick_reg;
  wire casc_wrap = LINK.frac_out_en & (casc_cnt_reg == CASC_LAST);

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      casc_cnt_reg <= '0;
      casc_tick_reg <= 1'b0;
    end
    else
    begin
      casc_cnt_reg <= (!LINK.frac_out_en || casc_wrap) ? '0 : casc_cnt_reg + 1'b1;
      casc_tick_reg <= casc_wrap;
    end
  end
  assign LINK.casc_ref_tick = casc_tick_reg;

  // State, outputs and link answers
  logic group_started_reg;
  logic [NUM_CH-1:0] chan_started_reg;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state_reg <= ST_IDLE;
      align_cnt_reg <= '0;
      en_q_reg <= '0;
      TX_ACTIVE <= '0;
      WORD_LOAD <= '0;
      SRC_MASTER <= '0;
      group_started_reg <= 1'b0;
      chan_started_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      align_cnt_reg <= align_cnt_next;
      en_q_reg <= LINK.chan_en;
      TX_ACTIVE <= active_next;
      WORD_LOAD <= tick_sel & active_next;
      SRC_MASTER <= {NUM_CH{bonded}};
      group_started_reg <= align_done;
      chan_started_reg <= go & LINK.chan_en;
    end
  end
  assign LINK.group_started = group_started_reg;
  assign LINK.chan_started = chan_started_reg;
endmodule
`default_nettype wire

// ### design/bca_host.sv
// Fabric and synth control end: placement checks, cascade, start issue
`timescale 1ns/100ps
`default_nettype none
module bca_host #(
  parameter int NUM_CH = bca_pkg::NUM_CH_DEF,
  parameter int BANK_CH = bca_pkg::BANK_CH_DEF,
  parameter int POS_W = bca_pkg::POS_W_DEF,
  parameter int PLL_ID_W = bca_pkg::PLL_ID_W_DEF
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Link to channel group
  bca_if.host LINK,
  // Configuration from user logic
  input wire logic [1:0] MODE,
  input wire logic [NUM_CH-1:0] CHAN_EN,
  input wire logic [NUM_CH*POS_W-1:0] LANE_POS,
  input wire logic [NUM_CH*PLL_ID_W-1:0] PLL_ID,
  input wire logic [1:0] FRAC_CASC_LEN,
  input wire logic DOWNSTREAM_FRAC,
  // Synth status and start request
  input wire logic PLL_LOCK,
  input wire logic RECAL_DONE,
  input wire logic START,
  // Status
  output logic PLACE_ERR,
  output logic PLL_ERR,
  output logic CASC_ERR,
  output logic RECAL_REQ,
  output logic READY,
  output logic GROUP_UP
);
  generate
    if (NUM_CH < 2 || POS_W < $clog2(NUM_CH) || PLL_ID_W < 1)
    begin : g_bad
      $error("bca_host: parameter values not supported");
    end
  endgenerate

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECAL = 2'b01,
    ST_WAIT = 2'b10,
    ST_READY = 2'b11
  } bca_host_t;

  bca_host_t state_reg, state_next;

  // Placement and source checks
  logic [NUM_CH-1:0] pos_ok;
  logic [NUM_CH-1:0] id_ok;
  genvar k;
  generate
    for (k = 0; k < NUM_CH; k++)
    begin : g_chk
      if (k == 0)
      begin : g_first
        assign pos_ok[k] = 1'b1;
        assign id_ok[k] = 1'b1;
      end
      else
      begin : g_rest
        assign pos_ok[k] = LANE_POS[k*POS_W +: POS_W]
          == LANE_POS[(k-1)*POS_W +: POS_W] + POS_W'(1);
        assign id_ok[k] = PLL_ID[k*PLL_ID_W +: PLL_ID_W] == PLL_ID[0 +: PLL_ID_W];
      end
    end
  endgenerate

  // Analog-only groups may sit anywhere; full bonding must be ascending
  wire place_bad = bca_pkg::is_pcs_bonded(MODE) & ~&pos_ok;
  wire wide = NUM_CH > BANK_CH;
  wire pll_bad = bca_pkg::is_bonded(MODE) & wide & ~&id_ok;
  wire casc_bad = FRAC_CASC_LEN > bca_pkg::MAX_FRAC_CASCADE;
  wire cfg_bad = place_bad | pll_bad | casc_bad;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (PLL_LOCK && !cfg_bad)
          state_next = DOWNSTREAM_FRAC ? ST_RECAL : ST_READY;
      end
      ST_RECAL:
        state_next = ST_WAIT;
      ST_WAIT:
      begin
        if (RECAL_DONE)
          state_next = ST_READY;
      end
      ST_READY:
      begin
        if (!PLL_LOCK || cfg_bad)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  wire ready_next = (state_next == ST_READY);

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state_reg <= ST_IDLE;
      PLACE_ERR <= 1'b0;
      PLL_ERR <= 1'b0;
      CASC_ERR <= 1'b0;
      RECAL_REQ <= 1'b0;
      READY <= 1'b0;
      GROUP_UP <= 1'b0;
      LINK.mode <= bca_pkg::MODE_NONBOND;
      LINK.serial_clk_ok <= 1'b0;
      LINK.start_req <= 1'b0;
      LINK.chan_en <= '0;
      LINK.frac_out_en <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      PLACE_ERR <= place_bad;
      PLL_ERR <= pll_bad;
      CASC_ERR <= casc_bad;
      RECAL_REQ <= (state_next == ST_RECAL);
      READY <= ready_next;
      // Set wins over the clear when leaving ready
      GROUP_UP <= LINK.group_started | (GROUP_UP & ready_next);
      LINK.mode <= MODE;
      LINK.serial_clk_ok <= ready_next;
      LINK.start_req <= START & (state_reg == ST_READY) & ready_next;
      LINK.chan_en <= CHAN_EN & {NUM_CH{ready_next}};
      LINK.frac_out_en <= (FRAC_CASC_LEN != 2'h0) & ~casc_bad;
    end
  end
endmodule
`default_nettype wire

// ### design/bca_if.sv
// Link between fabric/synth control end and the bonded channel group
`timescale 1ns/100ps
`default_nettype none
interface bca_if #(
  parameter int NUM_CH = bca_pkg::NUM_CH_DEF
);
  // Fabric side to channel group
  logic [1:0] mode;
  logic serial_clk_ok;
  logic start_req;
  logic [NUM_CH-1:0] chan_en;
  logic frac_out_en;
  // Channel group to fabric side
  logic casc_ref_tick;
  logic group_started;
  logic [NUM_CH-1:0] chan_started;

  modport dev (
    input mode, serial_clk_ok, start_req, chan_en, frac_out_en,
    output casc_ref_tick, group_started, chan_started
  );
  modport host (
    output mode, serial_clk_ok, start_req, chan_en, frac_out_en,
    input casc_ref_tick, group_started, chan_started
  );
endinterface
`default_nettype wire

// ### design/bca_pkg.sv
// Shared constants and decode helpers for bonded channel start alignment
package bca_pkg;
  // Bonding modes
  localparam logic [1:0] MODE_NONBOND = 2'h0;
  localparam logic [1:0] MODE_PMA = 2'h1;
  localparam logic [1:0] MODE_PMA_PCS = 2'h2;
  // Group size and layout defaults
  localparam int NUM_CH_DEF = 10;
  localparam int BANK_CH_DEF = 6;
  localparam int POS_W_DEF = 5;
  localparam int PLL_ID_W_DEF = 3;
  // Start condition delay per channel hop, in parallel clock cycles
  localparam int HOP_CYCLES = 2;
  // Serial words per parallel clock period, divider ratio
  localparam int WORD_DIV_DEF = 4;
  // Output divider ratio of the fractional synth on the cascading net
  localparam int CASC_DIV_DEF = 4;
  // Longest chain of fractional synths allowed
  localparam logic [1:0] MAX_FRAC_CASCADE = 2'h2;

  function automatic logic is_bonded(input logic [1:0] mode);
    is_bonded = (mode == MODE_PMA) || (mode == MODE_PMA_PCS);
  endfunction

  function automatic logic is_pcs_bonded(input logic [1:0] mode);
    is_pcs_bonded = (mode == MODE_PMA_PCS);
  endfunction
endpackage

// ### test/bca_properties.sv
// Interface assertions for bonded start alignment
`timescale 1ns/100ps
`default_nettype none
module bca_properties #(
  parameter int NUM_CH = 10
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Interface signals
  input wire logic [1:0] mode,
  input wire logic serial_clk_ok,
  input wire logic start_req,
  input wire logic [NUM_CH-1:0] chan_en,
  input wire logic frac_out_en,
  input wire logic casc_ref_tick,
  input wire logic group_started,
  input wire logic [NUM_CH-1:0] chan_started
);
  // Centre master, so the far end is NUM_CH/2 hops away
  localparam int ALIGN = 2 * (NUM_CH / 2);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  property p_ch_delay;
    (mode == 2'h2 && |chan_started) |-> $past(start_req, ALIGN + 1);
  endproperty
  a_ch_delay: assert property (p_ch_delay) else $error("start lag wrong");
  property p_grp_delay;
    group_started |-> $past(start_req, ALIGN + 2);
  endproperty
  a_grp_delay: assert property (p_grp_delay) else $error("group lag wrong");
  property p_ch_all;
    (mode == 2'h2 && |chan_started) |-> chan_started == chan_en;
  endproperty
  a_ch_all: assert property (p_ch_all) else $error("channels not aligned");
  property p_req_pulse;
    start_req |=> !start_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("start not a pulse");
  property p_req_ready;
    start_req |-> serial_clk_ok;
  endproperty
  a_req_ready: assert property (p_req_ready) else $error("start without clock");
  property p_casc_first;
    $rose(frac_out_en) ##1 frac_out_en[*4] |-> casc_ref_tick;
  endproperty
  a_casc_first: assert property (p_casc_first) else $error("first tick late");
  property p_casc_gap;
    casc_ref_tick |=> !casc_ref_tick[*3];
  endproperty
  a_casc_gap: assert property (p_casc_gap) else $error("tick spacing");
  property p_casc_en;
    casc_ref_tick |-> $past(frac_out_en);
  endproperty
  a_casc_en: assert property (p_casc_en) else $error("tick while off");
  property p_indep;
    (mode != 2'h2 && $stable(mode)) |=>
      chan_started == ($past(chan_en) & ~$past(chan_en, 2));
  endproperty
  a_indep: assert property (p_indep) else $error("unbonded start wrong");
endmodule
`default_nettype wire

// ### test/bonded_channel_start_alignment_tb.sv
// Bench joining both ends of bonded start alignment
`timescale 1ns/100ps
`default_nettype none
module bonded_channel_start_alignment_tb;
  localparam int NCH = 10;
  localparam int PW = 5;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [1:0] mode = 2'h0;
  logic [NCH-1:0] ch_en = '0;
  logic [NCH*PW-1:0] lane_pos = '0;
  logic [NCH*3-1:0] pll_id = '0;
  logic [1:0] casc_len = 2'h0;
  logic down_frac = 1'h1;
  logic lock = 1'h0;
  logic recal_done = 1'h0;
  logic start = 1'h0;
  logic place_err, pll_err, casc_err, recal_req, ready, group_up;
  logic [NCH-1:0] tx_active, word_load, src_master;
  int error_cnt = 0;
  int samples_checked = 0;
  int n;
  bca_if #(.NUM_CH(NCH)) link ();
  bca_host #(.NUM_CH(NCH)) bca_host_inst (.SYS_CLK(clk), .RST(rst), .LINK(link),
    .MODE(mode), .CHAN_EN(ch_en), .LANE_POS(lane_pos), .PLL_ID(pll_id),
    .FRAC_CASC_LEN(casc_len), .DOWNSTREAM_FRAC(down_frac), .PLL_LOCK(lock),
    .RECAL_DONE(recal_done), .START(start), .PLACE_ERR(place_err), .PLL_ERR(pll_err),
    .CASC_ERR(casc_err), .RECAL_REQ(recal_req), .READY(ready), .GROUP_UP(group_up));
  bca_dev #(.NUM_CH(NCH)) bca_dev_inst (.SYS_CLK(clk), .RST(rst), .LINK(link),
    .TX_ACTIVE(tx_active), .WORD_LOAD(word_load), .SRC_MASTER(src_master));
  bca_properties #(.NUM_CH(NCH)) bca_properties_inst (.SYS_CLK(clk), .RST(rst),
    .mode(link.mode), .serial_clk_ok(link.serial_clk_ok), .start_req(link.start_req),
    .chan_en(link.chan_en), .frac_out_en(link.frac_out_en),
    .casc_ref_tick(link.casc_ref_tick), .group_started(link.group_started),
    .chan_started(link.chan_started));
  always #50 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Inputs change 1 ns after the edge, so outputs are settled too
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Lock held low so that errors alone are seen
  task automatic t_errors();
    mode = 2'h2;
    lane_pos[PW-1:0] = 5'h1;
    lane_pos[2*PW-1:PW] = 5'h0;
    tick(2);
    chk("place_err", 1, place_err);
    chk("ready", 0, ready);
    // Same scattered placement is fine for an analog-only group
    mode = 2'h1;
    tick(2);
    chk("place_err", 0, place_err);
    lane_pos[PW-1:0] = 5'h0;
    lane_pos[2*PW-1:PW] = 5'h1;
    mode = 2'h1;
    pll_id[2:0] = 3'h1;
    tick(2);
    chk("pll_err", 1, pll_err);
    pll_id = '0;
    casc_len = 2'h3;
    tick(2);
    chk("casc_err", 1, casc_err);
    casc_len = 2'h2;
    tick(2);
    chk("errors", 0, {place_err, pll_err, casc_err});
  endtask
  task automatic t_bringup();
    lock = 1'h1;
    for (int i = 0; i < 10 && recal_req !== 1'h1; i++) tick(1);
    chk("recal_req", 1, recal_req);
    tick(1);
    chk("recal_req", 0, recal_req);
    tick(1);
    // Still waiting on the recalibration
    chk("ready", 0, ready);
    recal_done = 1'h1;
    tick(1);
    recal_done = 1'h0;
    // Ready is registered on the edge that sees the recalibration finish
    chk("ready", 1, ready);
    n = 0;
    for (int i = 0; i < 16; i++)
    begin
      tick(1);
      n += link.casc_ref_tick;
    end
    chk("casc ticks", 4, n);
  endtask
  task automatic t_bonded();
    mode = 2'h2;
    ch_en = '1;
    tick(3);
    chk("src_master", 10'h3ff, src_master);
    chk("tx_active", 0, tx_active);
    start = 1'h1;
    tick(1);
    start = 1'h0;
    chk("start_req", 1, link.start_req);
    n = 0;
    for (int i = 0; i < 30 && link.chan_started === '0; i++)
    begin
      tick(1);
      n++;
    end
    chk("start lag", 11, n);
    chk("chan_started", 10'h3ff, link.chan_started);
    chk("tx_active", 10'h3ff, tx_active);
    tick(1);
    chk("group_started", 1, link.group_started);
    tick(1);
    chk("group_up", 1, group_up);
  endtask
  // Far bank rides one extra net stage behind bank 0
  task automatic t_words();
    ch_en = '0;
    mode = 2'h1;
    tick(3);
    ch_en = '1;
    tick(3);
    for (int i = 0; i < 10 && word_load[0] !== 1'h1; i++) tick(1);
    chk("bank0 load", 10'h03f, word_load);
    tick(1);
    chk("far load", 10'h3c0, word_load);
    tick(3);
    chk("bank0 again", 10'h03f, word_load);
    chk("src_master", 10'h3ff, src_master);
  endtask
  task automatic t_nonbond();
    ch_en = '0;
    mode = 2'h0;
    tick(3);
    chk("src_master", 0, src_master);
    ch_en = 10'h008;
    tick(2);
    chk("tx_active", 10'h008, tx_active);
    n = 0;
    for (int i = 0; i < 8; i++)
    begin
      tick(1);
      n += word_load[3];
      chk("other loads", 0, word_load & 10'h3f7);
    end
    chk("local loads", 2, n);
  endtask
  initial
  begin
    for (int k = 0; k < NCH; k++) lane_pos[k*PW +: PW] = k[PW-1:0];
    tick(10);
    rst = 1'h0;
    t_errors();
    t_bringup();
    t_bonded();
    t_words();
    t_nonbond();
    stop_test();
  end
  initial
  begin
    #500000;
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
